// File: src/sensor_output_pkg.sv
// constants shared by the sensor output stage and its density modulator
package sensor_output_pkg;
  // bit positions in configuration word 02
  localparam int unsigned CFG_DENSITY_EN_BIT = 9;
  localparam int unsigned CFG_ADDR_MSB       = 6;
  localparam int unsigned CFG_ADDR_LSB       = 0;
  // status byte bit positions
  localparam int unsigned ST_ZERO_BIT  = 7;
  localparam int unsigned ST_POWER_BIT = 6;
  localparam int unsigned ST_BUSY_BIT  = 5;
  localparam int unsigned ST_MODE_MSB  = 4;
  localparam int unsigned ST_MODE_LSB  = 3;
  localparam int unsigned ST_MEMERR_BIT = 2;
  localparam int unsigned ST_OVF_BIT   = 1;
  localparam int unsigned ST_SAT_BIT   = 0;
  // operating mode codes reported in status bits 4:3
  localparam logic [1:0] MODE_NORMAL  = 2'h0;
  localparam logic [1:0] MODE_COMMAND = 2'h1;
  localparam logic [1:0] MODE_TEST    = 2'h2;
  // kind of the result that completes the current command
  localparam logic [1:0] KIND_NONMEAS = 2'h0;
  localparam logic [1:0] KIND_COMP    = 2'h1;
  localparam logic [1:0] KIND_RAW_CAP = 2'h2;
  localparam logic [1:0] KIND_RAW_TMP = 2'h3;
  // result word: sensor word then temperature word, 24 bits each
  localparam int unsigned RESULT_W    = 48;
  localparam int unsigned RESULT_BYTES = 6;
  localparam int unsigned DENSITY_W   = 16;
  localparam int unsigned RES_SENS_MSB = 47;
  // command bytes kept per write, high-speed mode sends three
  localparam int unsigned CMD_MAX_BYTES = 3;
  // modulator update divider: 125 MHz / 8
  localparam int unsigned DENSITY_DIV = 8;
  localparam int unsigned DIV_W = 3;
endpackage

// File: src/density_modulator.sv
// first-order sigma-delta pulse-density modulator
`timescale 1ns/1ps
module density_modulator (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // control
  input  wire logic        enable_in,
  input  wire logic [15:0] target_in,
  // stream
  output logic             density_out
);

  logic [2:0]  div_r;
  logic        tick;
  logic [15:0] acc_r;
  logic [16:0] sum;

  assign tick = (div_r ==
    3'(sensor_output_pkg::DENSITY_DIV - 1));
  assign sum = {1'b0, acc_r} + {1'b0, target_in};

  always_ff @(posedge clk_in) begin
    if (rst_in || !enable_in) begin
      div_r <= 3'h0;
    end else if (tick) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end

  // carry of the accumulator is the density bit
  always_ff @(posedge clk_in) begin
    if (rst_in || !enable_in) begin
      acc_r       <= 16'h0000;
      density_out <= 1'b0;
    end else if (tick) begin
      acc_r       <= sum[15:0];
      density_out <= sum[16];
    end
  end

  a_idle_low: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !enable_in |=> !density_out)
    else $error("density output active while disabled");

  a_full_scale: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (enable_in && tick && target_in == 16'hFFFF && acc_r != 16'h0000)
    |=> density_out)
    else $error("full scale target gave no pulse");

endmodule

// File: src/sensor_output_stage.sv
// bus slave port and density output of the sensor conditioner
// Function
// - density output runs only in cyclic mode; sleep is held off then
// - config word 02 bit 9 enables density stream, started after reset
// - density stream carries only compensated sensor result, sigma-delta
// - modulator input is a 16-bit word
// - slave address loaded from config word 02 bits 6:0 after reset
// - every read answers status byte then last command's data
// - repeated reads give same data; new command clears held data
// - status bit 7 reads zero
// - status bit 6 reads one while powered
// - status bit 5 shows busy; commands received while busy dropped
// - status bits 4:3 give operating mode
// - status bit 2 shows failed memory integrity check
// - status bit 1 flags capacitive overflow, never for temperature
// - status bit 0 flags saturation of measurement, else zero
// - seven-bit addressing only, ten-bit not recognised
// - status may be read any time; master waits for busy clear
// - command codes identical on every interface
// - bus clock from 0.1 to 3.4 MHz supported
// - measure result is 24-bit sensor then 24-bit temperature word
`timescale 1ns/1ps
module sensor_output_stage (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n_out,
  // configuration memory
  input  wire logic [15:0] config_word_in,
  input  wire logic        mem_error_in,
  // measurement core
  input  wire logic [1:0]  mode_in,
  input  wire logic        cyclic_active_in,
  input  wire logic        result_valid_in,
  input  wire logic [47:0] result_data_in,
  input  wire logic [1:0]  result_kind_in,
  input  wire logic        adc_overflow_in,
  input  wire logic        math_sat_in,
  // command to the core
  output logic             cmd_valid_out,
  output logic [7:0]       cmd_code_out,
  output logic [15:0]      cmd_arg_out,
  output logic [1:0]       cmd_len_out,
  // power and density output
  output logic             no_sleep_out,
  output logic             density_out
);

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_WR_BYTE, S_WR_ACK, S_RD_BYTE, S_RD_ACK
  } bus_state_t;
  bus_state_t  state_r;
  logic [1:0]  scl_sync_r;
  logic [1:0]  sda_sync_r;
  logic        scl_d_r;
  logic        sda_d_r;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic        cfg_done_r;
  logic [6:0]  slave_addr_r;
  logic        density_en_r;
  logic [7:0]  rx_sh_r;
  logic [7:0]  tx_sh_r;
  logic [3:0]  bit_cnt_r;
  logic        rd_dir_r;
  logic [1:0]  wr_cnt_r;
  logic [23:0] wr_bytes_r;
  logic [2:0]  rd_idx_r;
  logic        busy_r;
  logic        ovf_r;
  logic        sat_r;
  logic [47:0] result_r;
  logic [15:0] target_r;
  logic [7:0]  status_byte;
  logic        drive_low;
  logic        density_run;

  // pins come from the master's clock: two flops before use
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
    end
  end

  // 8 ns sampling keeps margin at a 3.4 MHz bus clock
  assign scl_rise  = scl_sync_r[1] && !scl_d_r;
  assign scl_fall  = !scl_sync_r[1] && scl_d_r;
  assign start_det = scl_sync_r[1] && scl_d_r && sda_d_r
                     && !sda_sync_r[1];
  assign stop_det  = scl_sync_r[1] && scl_d_r && !sda_d_r
                     && sda_sync_r[1];

  // configuration is caught once, the cycle after reset release
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg_done_r   <= 1'b0;
      slave_addr_r <= 7'h00;
      density_en_r <= 1'b0;
    end else if (!cfg_done_r) begin
      cfg_done_r   <= 1'b1;
      slave_addr_r <= config_word_in[sensor_output_pkg::CFG_ADDR_MSB:
                                     sensor_output_pkg::CFG_ADDR_LSB];
      density_en_r <=
        config_word_in[sensor_output_pkg::CFG_DENSITY_EN_BIT];
    end
  end

  // status byte built live so a read always shows current state
  always_comb begin
    status_byte = 8'h00;
    status_byte[sensor_output_pkg::ST_ZERO_BIT]  = 1'b0;
    status_byte[sensor_output_pkg::ST_POWER_BIT] = 1'b1;
    status_byte[sensor_output_pkg::ST_BUSY_BIT]  = busy_r;
    status_byte[sensor_output_pkg::ST_MODE_MSB:
                sensor_output_pkg::ST_MODE_LSB]  = mode_in;
    status_byte[sensor_output_pkg::ST_MEMERR_BIT] = mem_error_in;
    status_byte[sensor_output_pkg::ST_OVF_BIT]   = ovf_r;
    status_byte[sensor_output_pkg::ST_SAT_BIT]   = sat_r;
  end

  function automatic logic [7:0] resp_byte(input logic [2:0] idx,
                                           input logic [7:0] st,
                                           input logic [47:0] res);
    logic [7:0] b;
    b = 8'h00;
    if (idx == 3'h0) begin
      b = st;
    end else if (idx <= 3'(sensor_output_pkg::RESULT_BYTES)) begin
      b = res[8'(sensor_output_pkg::RES_SENS_MSB) - 8'(idx - 3'h1) * 8'h08
              -: 8];
    end
    return b;
  endfunction

  // bus state machine, moves only on detected pin events
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r   <= S_IDLE;
      bit_cnt_r <= 4'h0;
      rx_sh_r   <= 8'h00;
      tx_sh_r   <= 8'h00;
      rd_dir_r  <= 1'b0;
      wr_cnt_r  <= 2'h0;
      wr_bytes_r <= 24'h000000;
      rd_idx_r  <= 3'h0;
    end else if (start_det) begin
      state_r   <= S_ADDR;
      bit_cnt_r <= 4'h0;
      wr_cnt_r  <= 2'h0;
      rd_idx_r  <= 3'h0;
    end else if (stop_det) begin
      state_r <= S_IDLE;
    end else if (scl_rise) begin
      if (state_r == S_ADDR || state_r == S_WR_BYTE) begin
        rx_sh_r   <= {rx_sh_r[6:0], sda_sync_r[1]};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (state_r == S_RD_BYTE) begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (state_r == S_RD_ACK) begin
        // master nack ends the answer
        if (sda_sync_r[1]) begin
          state_r <= S_IDLE;
        end
      end
    end else if (scl_fall) begin
      case (state_r)
        S_ADDR: begin
          if (bit_cnt_r == 4'h8) begin
            // exact seven-bit match; ten-bit headers match only if the address is 7'h78 to 7'h7B
            if (rx_sh_r[7:1] == slave_addr_r && cfg_done_r) begin
              state_r  <= S_ADDR_ACK;
              rd_dir_r <= rx_sh_r[0];
            end else begin
              state_r <= S_IDLE;
            end
          end
        end
        S_ADDR_ACK: begin
          bit_cnt_r <= 4'h0;
          if (rd_dir_r) begin
            state_r  <= S_RD_BYTE;
            tx_sh_r  <= resp_byte(3'h0, status_byte, result_r);
            rd_idx_r <= 3'h1;
          end else begin
            state_r <= S_WR_BYTE;
          end
        end
        S_WR_BYTE: begin
          if (bit_cnt_r == 4'h8) begin
            state_r <= S_WR_ACK;
            // bytes past the third are acknowledged and dropped
            if (wr_cnt_r < 2'(sensor_output_pkg::CMD_MAX_BYTES)) begin
              wr_bytes_r <= {wr_bytes_r[15:0], rx_sh_r};
              wr_cnt_r   <= wr_cnt_r + 2'h1;
            end
          end
        end
        S_WR_ACK: begin
          state_r   <= S_WR_BYTE;
          bit_cnt_r <= 4'h0;
        end
        S_RD_BYTE: begin
          if (bit_cnt_r == 4'h8) begin
            state_r <= S_RD_ACK;
          end else begin
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
          end
        end
        S_RD_ACK: begin
          state_r   <= S_RD_BYTE;
          bit_cnt_r <= 4'h0;
          tx_sh_r   <= resp_byte(rd_idx_r, status_byte, result_r);
          if (rd_idx_r != 3'h7) begin
            rd_idx_r <= rd_idx_r + 3'h1;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // open-drain pin: only ever pulled low, output enable active low
  assign drive_low = (state_r == S_ADDR_ACK) || (state_r == S_WR_ACK)
                     || (state_r == S_RD_BYTE && !tx_sh_r[7]);
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sda_oe_n_out <= 1'b1;
    end else begin
      sda_oe_n_out <= !drive_low;
    end
  end
  assign sda_out = 1'b0;

  // command leaves at stop; while busy it is dropped, not queued
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cmd_valid_out <= 1'b0;
      cmd_code_out  <= 8'h00;
      cmd_arg_out   <= 16'h0000;
      cmd_len_out   <= 2'h0;
    end else begin
      cmd_valid_out <= 1'b0;
      if (stop_det && state_r == S_WR_BYTE && wr_cnt_r != 2'h0
          && !busy_r) begin
        cmd_valid_out <= 1'b1;
        cmd_len_out   <= wr_cnt_r;
        // code passed unchanged, same set as any other interface
        if (wr_cnt_r == 2'h1) begin
          cmd_code_out <= wr_bytes_r[7:0];
          cmd_arg_out  <= 16'h0000;
        end else if (wr_cnt_r == 2'h2) begin
          cmd_code_out <= wr_bytes_r[15:8];
          cmd_arg_out  <= {wr_bytes_r[7:0], 8'h00};
        end else begin
          cmd_code_out <= wr_bytes_r[23:16];
          cmd_arg_out  <= wr_bytes_r[15:0];
        end
      end
    end
  end

  // result store and status flags
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_r   <= 1'b0;
      result_r <= 48'h000000000000;
      ovf_r    <= 1'b0;
      sat_r    <= 1'b0;
    end else if (cmd_valid_out) begin
      busy_r   <= 1'b1;
      result_r <= 48'h000000000000;
      ovf_r    <= 1'b0;
      sat_r    <= 1'b0;
    end else if (result_valid_in && busy_r) begin
      busy_r   <= 1'b0;
      result_r <= result_data_in;
      ovf_r    <= adc_overflow_in &&
                  (result_kind_in == sensor_output_pkg::KIND_COMP ||
                   result_kind_in == sensor_output_pkg::KIND_RAW_CAP);
      sat_r    <= math_sat_in &&
                  (result_kind_in != sensor_output_pkg::KIND_NONMEAS);
    end
  end

  // cyclic results arrive without a command and still feed the stream
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      target_r <= 16'h0000;
    end else if (result_valid_in &&
                 result_kind_in == sensor_output_pkg::KIND_COMP) begin
      target_r <= result_data_in[sensor_output_pkg::RES_SENS_MSB -:
                                 sensor_output_pkg::DENSITY_W];
    end
  end

  assign density_run  = density_en_r && cyclic_active_in;
  assign no_sleep_out = density_run;

  density_modulator u_density (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .enable_in   (density_run),
    .target_in   (target_r),
    .density_out (density_out)
  );

  a_status_fixed: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (scl_fall && state_r == S_ADDR_ACK && rd_dir_r) |=> tx_sh_r[7:6] == 2'h1)
    else $error("status top bits wrong");
  a_addr_loaded: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $rose(cfg_done_r) |-> slave_addr_r == $past(config_word_in[6:0]))
    else $error("slave address not loaded");
  a_cmd_sets_busy: assert property (
    @(posedge clk_in) disable iff (rst_in)
    cmd_valid_out |-> !$past(busy_r) ##1 busy_r)
    else $error("command taken while busy");
  a_cmd_clears_data: assert property (
    @(posedge clk_in) disable iff (rst_in)
    cmd_valid_out |=> result_r == 48'h000000000000 && !sat_r)
    else $error("old data survived a command");
  a_result_held: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (result_valid_in && busy_r && !cmd_valid_out) |=>
      result_r == $past(result_data_in) && !busy_r)
    else $error("result not stored");
  a_temp_no_ovf: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (result_valid_in && busy_r && !cmd_valid_out &&
     result_kind_in == sensor_output_pkg::KIND_RAW_TMP) |=> !ovf_r)
    else $error("overflow set by temperature");
  a_nonmeas_no_sat: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (result_valid_in && busy_r && !cmd_valid_out &&
     result_kind_in == sensor_output_pkg::KIND_NONMEAS) |=> !sat_r)
    else $error("saturation set by non-measurement");
  a_target_update: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (result_valid_in && result_kind_in == sensor_output_pkg::KIND_COMP)
    |=> target_r == $past(result_data_in[47:32]))
    else $error("density target not updated");
  a_start_addr: assert property (
    @(posedge clk_in) disable iff (rst_in)
    start_det |=> state_r == S_ADDR && bit_cnt_r == 4'h0)
    else $error("start not recognised");
endmodule

// File: dv/i2c_master_model.sv
// behavioural bus master for the sensor output stage
`timescale 1ns/1ps
module i2c_master_model (
  // clock
  input  wire logic clk_in,
  // bus
  input  wire logic sda_line_in,
  output logic      scl_out,
  output logic      sda_out
);
  // idle bus: both lines released, clock stands still
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // quarter of a 160 ns bus period in system clocks
  task automatic qtr();
    repeat (5) @(posedge clk_in);
  endtask
  // data set mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    qtr();
    sda_out <= b;
    qtr();
    scl_out <= 1'b1;
    qtr();
    s = sda_line_in;
    qtr();
    scl_out <= 1'b0;
  endtask
  task automatic start();
    qtr();
    sda_out <= 1'b0;
    qtr();
    scl_out <= 1'b0;
  endtask
  task automatic stop();
    qtr();
    sda_out <= 1'b0;
    qtr();
    scl_out <= 1'b1;
    qtr();
    sda_out <= 1'b1;
    qtr();
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // one command byte only: the bench sends its three-byte command with wr_byte
  task automatic write_cmd(input logic [6:0] a, input logic [7:0] c,
                           output logic ack);
    logic k;
    start();
    wr_byte({a, 1'b0}, ack);
    if (ack)
      wr_byte(c, k);
    stop();
  endtask
  // last byte gets a nack so the slave lets go of the line
  task automatic read_seq(input logic [6:0] a, input int n,
                          output logic [7:0] d [7], output logic ack);
    logic s;
    start();
    wr_byte({a, 1'b1}, ack);
    for (int i = 0; i < n; i++) begin
      for (int b = 7; b >= 0; b--)
        bit_io(1'b1, d[i][b]);
      bit_io(i == n - 1, s);
    end
    stop();
  endtask
endmodule

// File: dv/tb_top.sv
// self-checking bench for the sensor output stage
`timescale 1ns/1ps
module tb_top;
  logic        clk_in, rst_in, scl, m_sda, sda_oe_n, dut_sda;
  logic        mem_err, cyc, rv, ovf, sat, cv, ns, dens, ack;
  logic [15:0] cfg, ca;
  logic [1:0]  mode, rk, cl;
  logic [47:0] rd;
  logic [7:0]  cc;
  logic [7:0]  rb [7];
  int          err_total, tests_run, cmd_cnt, ones, o0;
  logic [7:0]  cmd_tab [4] = '{8'hAA, 8'h02, 8'hA2, 8'hA6};
  // address byte, then code and two argument bytes
  logic [7:0]  hs_tab [4] = '{8'h54, 8'h32, 8'h12, 8'h34};
  // compensated, none, raw sensor, raw temperature
  logic [1:0]  kind_tab [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
  logic [47:0] data_tab [4] = '{48'hC00000_123456, 48'hBEEF00_000000,
                                48'h00ABCD_000000, 48'h123456_000000};
  // open drain with pull-up: low if either party pulls
  wire sda_line = (sda_oe_n ? 1'b1 : dut_sda) & m_sda;
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  sensor_output_stage sensor_output_stage_inst (
    .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_line),
    .sda_out(dut_sda), .sda_oe_n_out(sda_oe_n), .config_word_in(cfg),
    .mem_error_in(mem_err), .mode_in(mode), .cyclic_active_in(cyc),
    .result_valid_in(rv), .result_data_in(rd), .result_kind_in(rk),
    .adc_overflow_in(ovf), .math_sat_in(sat), .cmd_valid_out(cv),
    .cmd_code_out(cc), .cmd_arg_out(ca), .cmd_len_out(cl),
    .no_sleep_out(ns), .density_out(dens));
  i2c_master_model i2c_master_model_inst (
    .clk_in(clk_in), .sda_line_in(sda_line), .scl_out(scl),
    .sda_out(m_sda));
  always @(posedge clk_in) begin
    cmd_cnt <= cmd_cnt + (cv === 1'b1);
    ones <= ones + (dens === 1'b1);
  end
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] st(input logic b, input logic [1:0] k);
    st = {2'b01, b, mode, mem_err, ovf && (k == 2'h1 || k == 2'h2),
          sat && k != 2'h0};
  endfunction
  task automatic give(input logic [1:0] k, input logic [47:0] d);
    @(posedge clk_in);
    rk <= k;
    rd <= d;
    rv <= 1'b1;
    @(posedge clk_in);
    rv <= 1'b0;
  endtask
  task automatic do_reset(input logic [15:0] c);
    cfg <= c;
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {rst_in, mem_err, cyc, rv, rk, rd, mode} = '0;
    {ovf, sat, cfg} = {2'b11, 16'h022A};
    {err_total, tests_run, cmd_cnt, ones} = '0;
    do_reset(16'h022A);
    for (int md = 0; md < 3; md++) begin
      mode <= md[1:0];
      mem_err <= md[0];
      i2c_master_model_inst.read_seq(7'h2A, 1, rb, ack);
      chk8(rb[0], st(1'b0, 2'h0));
    end
    {mode, mem_err} <= 3'b010;
    $display("test status modes done");
    i2c_master_model_inst.write_cmd(7'h2B, 8'hAA, ack);
    chk8(8'(ack), 8'h00);
    i2c_master_model_inst.write_cmd(7'h78, 8'hAA, ack);
    chk8(8'(ack), 8'h00);
    $display("test address done");
    for (int i = 0; i < 4; i++) begin
      i2c_master_model_inst.write_cmd(7'h2A, cmd_tab[i], ack);
      repeat (10) @(posedge clk_in);
      chk8(8'(cmd_cnt), 8'(i + 1));
      chk8(cc, cmd_tab[i]);
      chk8(8'(cl), 8'h01);
      i2c_master_model_inst.read_seq(7'h2A, 7, rb, ack);
      chk8(rb[0], st(1'b1, 2'h0));
      for (int j = 1; j < 7; j++)
        chk8(rb[j], 8'h00);
      if (i == 0) begin
        i2c_master_model_inst.write_cmd(7'h2A, 8'hA6, ack);
        repeat (10) @(posedge clk_in);
        chk8(8'(cmd_cnt), 8'h01);
      end
      {ovf, sat} <= {i != 2, i != 3};
      give(kind_tab[i], data_tab[i]);
      for (int r = 0; r < 2; r++) begin
        i2c_master_model_inst.read_seq(7'h2A, 7, rb, ack);
        chk8(rb[0], st(1'b0, kind_tab[i]));
        for (int j = 1; j < 7; j++)
          chk8(rb[j], data_tab[i][55 - 8 * j -: 8]);
      end
    end
    $display("test commands done");
    chk8(8'(ns), 8'h00);
    cyc <= 1'b1;
    @(posedge clk_in);
    chk8(8'(ns), 8'h01);
    // raw results came later, so only the compensated C000 may show
    o0 = ones;
    repeat (512) @(posedge clk_in);
    chk8(8'(ones - o0 >= 368 && ones - o0 <= 400), 8'h01);
    $display("test density done");
    i2c_master_model_inst.start();
    for (int j = 0; j < 4; j++)
      i2c_master_model_inst.wr_byte(hs_tab[j], ack);
    i2c_master_model_inst.stop();
    repeat (10) @(posedge clk_in);
    chk8(8'(cmd_cnt), 8'h05);
    chk8(cc, hs_tab[1]);
    chk8(8'(cl), 8'h03);
    chk8(ca[15:8], hs_tab[2]);
    chk8(ca[7:0], hs_tab[3]);
    // full-scale target: at most one step in the window lacks a pulse
    give(2'h1, 48'hFFFF00_000000);
    o0 = ones;
    repeat (512) @(posedge clk_in);
    chk8(8'(ones - o0 >= 480), 8'h01);
    $display("test three-byte command done");
    do_reset(16'h0031);
    i2c_master_model_inst.read_seq(7'h2A, 1, rb, ack);
    chk8(8'(ack), 8'h00);
    i2c_master_model_inst.read_seq(7'h31, 1, rb, ack);
    chk8(8'(ack), 8'h01);
    chk8(8'(ns), 8'h00);
    o0 = ones;
    repeat (256) @(posedge clk_in);
    chk8(8'(ones - o0), 8'h00);
    $display("test second reset done");
    final_report();
  end
  // the tests need about 24000 cycles
  initial begin
    repeat (90000) @(posedge clk_in);
    err_total++;
    final_report();
  end
endmodule
